// File: scs_analog_model.sv
/* Comparator stand-in holding an input level as a straight code.
   Assumes the trial DAC is straight binary. */
`timescale 1ns/1ps
`default_nettype none
module scs_analog_model (
  input  wire logic [19:0] level,
  input  wire logic [19:0] dac,
  output logic             above
);
  assign above = (level >= dac);
endmodule
`default_nettype wire

// File: scs_checker.sv
/* Port assertions for the sequencer.
   Bound to every scs_sequencer instance. */
`timescale 1ns/1ps
`default_nettype none
module scs_checker #(parameter int unsigned BIT_CYC = 3) (
  input wire logic                 mclk,
  input wire logic                 sys_rst,
  input wire logic                 reference_buffer_input_zero,
  input wire logic                 mode_write,
  input wire logic [15:0]          mode_wdata,
  input wire logic [15:0]          mode_rdata,
  input wire logic [19:0]          capacitive_trial_dac,
  input wire logic [19:0]          result_data,
  input wire scs_pkg::scs_status_t status,
  input wire scs_pkg::scs_refctl_t refctl
);
  localparam int DONE_LAT = 20 * BIT_CYC + 1;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence conv_entry; $rose(status.conv_busy); endsequence
  start_trial_a: assert property (conv_entry |->
    capacitive_trial_dac == 20'h80000) else $error("bad first trial");
  done_lat_a: assert property (conv_entry |->
    ##DONE_LAT status.conv_done) else $error("done late or early");
  no_early_a: assert property (conv_entry |->
    (status.conv_busy && !status.conv_done)[*8]) else $error("early end");
  back_track_a: assert property (status.conv_done |->
    !status.conv_busy && !status.analog_active) else $error("not tracking");
  switch_busy_a: assert property (
    status.sample_switch_open == status.conv_busy) else $error("switch");
  hold_res_a: assert property (!status.conv_done |->
    $stable(result_data)) else $error("result moved");
  mode_load_a: assert property (mode_write |=>
    mode_rdata == $past(mode_wdata)) else $error("mode not loaded");
  ref_first_a: assert property (refctl.first_ref_buffer_enable ==
    (!mode_rdata[4] && !reference_buffer_input_zero)) else $error("ref1");
  ref_second_a: assert property (refctl.second_ref_buffer_enable ==
    (!mode_rdata[0] && !reference_buffer_input_zero)) else $error("ref2");
endmodule
bind scs_sequencer scs_checker #(.BIT_CYC(BIT_CYC)) u_chk (.mclk, .sys_rst,
  .reference_buffer_input_zero, .mode_write, .mode_wdata, .mode_rdata,
  .capacitive_trial_dac, .result_data, .status, .refctl);
`default_nettype wire

// File: scs_pkg.sv
/*
  Shared constants and carrier types for the SAR conversion sequencer.
  Assumes a single 100 MHz clock domain.
*/
`default_nettype none
package scs_pkg;

  localparam int unsigned RES_BITS     = 20;
  localparam int unsigned MODE_BITS    = 16;
  // Mode register field positions
  localparam int unsigned MODE_REF2_PD = 0;
  localparam int unsigned MODE_OB_SEL  = 1;
  localparam int unsigned MODE_REF1_PD = 4;
  localparam logic [15:0] MODE_RST_VAL = 16'h0000;
  // Internal oscillator: one bit decision every BIT_TIME_NS
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned BIT_TIME_NS   = 30;
  localparam int unsigned BIT_CYCLES    =
    (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [19:0] RES_RST_VAL  = 20'h00000;
  localparam logic [19:0] SIGN_FLIP    = 20'h80000;

  typedef enum logic [1:0] {
    SCS_TRACK,
    SCS_CONVERT,
    SCS_LATCH
  } scs_phase_t;

  typedef struct packed {
    logic conv_busy;
    logic conv_done;
    logic analog_active;
    logic sample_switch_open;
  } scs_status_t;

  typedef struct packed {
    logic first_ref_buffer_enable;
    logic second_ref_buffer_enable;
  } scs_refctl_t;

endpackage
`default_nettype wire

// File: scs_sequencer.sv
/*
  SAR conversion sequencer for one converter channel: sampling, bit
  search, output coding, result holding and reference buffer control.
  Assumes the comparator answers within one bit period and that the mode
  register contents arrive from the serial interface on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module scs_sequencer #(
  parameter int unsigned RES_W   = scs_pkg::RES_BITS,
  parameter int unsigned BIT_CYC = scs_pkg::BIT_CYCLES
) (
  input  wire logic                        mclk,
  input  wire logic                        sys_rst,
  input  wire logic                        conversion_start_pin,
  input  wire logic                        comparator_above,
  input  wire logic                        reference_buffer_input_zero,
  input  wire logic                        mode_write,
  input  wire logic [scs_pkg::MODE_BITS-1:0] mode_wdata,
  output logic [scs_pkg::MODE_BITS-1:0]    mode_rdata,
  output logic [RES_W-1:0]                 capacitive_trial_dac,
  output logic [RES_W-1:0]                 result_data,
  output var scs_pkg::scs_status_t         status,
  output var scs_pkg::scs_refctl_t         refctl
);

  // --------------------------------------------------------------
  // Timing overview
  // --------------------------------------------------------------
  // The start pin is asynchronous, so it passes two flip-flops and
  // an edge detector: conversion begins on the third clock edge
  // after the pin rises. Start edges seen while busy are dropped,
  // so the host cannot stretch or restart a running search.
  // Each bit takes BIT_CYC clocks from the local timer alone, so
  // the conversion length never depends on the host; whatever is
  // left of the sample period is track time.
  // One extra latch cycle codes the result and moves it into the
  // holding register, so a read during the next search still sees
  // the previous result.

  // --------------------------------------------------------------
  // State record
  // --------------------------------------------------------------
  typedef struct packed {
    logic [1:0]                  start_sync;
    logic                        start_prev;
    scs_pkg::scs_phase_t         phase;
    logic [RES_W-1:0]            trial;
    logic [RES_W-1:0]            weight;
    logic [7:0]                  tick;
    logic [scs_pkg::MODE_BITS-1:0] mode;
    logic [RES_W-1:0]            held;
    logic                        done;
  } scs_state_t;

  scs_state_t st_r;
  scs_state_t st_nxt;

  // Raw search result is straight binary with midscale at 0x80000.
  // Two's complement is that code with its top bit inverted; offset
  // binary is the raw code itself.
  function automatic logic [RES_W-1:0] scs_code(
    input logic [RES_W-1:0] raw,
    input logic             ob
  );
    scs_code = ob ? raw
                  : (raw ^ RES_W'(scs_pkg::SIGN_FLIP));
  endfunction

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb begin
    logic [RES_W-1:0] decided;
    decided = st_r.trial;
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.start_sync = {st_r.start_sync[0], conversion_start_pin};
    st_nxt.start_prev = st_r.start_sync[1];
    if (mode_write) begin
      st_nxt.mode = mode_wdata;
    end
    case (st_r.phase)
      scs_pkg::SCS_TRACK: begin
        if (st_r.start_sync[1] && !st_r.start_prev) begin
          st_nxt.phase  = scs_pkg::SCS_CONVERT;
          st_nxt.weight = {1'b1, {(RES_W-1){1'b0}}};
          st_nxt.trial  = {1'b1, {(RES_W-1){1'b0}}};
          st_nxt.tick   = 8'h00;
        end
      end
      scs_pkg::SCS_CONVERT: begin
        if (st_r.tick == 8'(BIT_CYC - 1)) begin
          st_nxt.tick = 8'h00;
          if (!comparator_above) begin
            decided = st_r.trial & ~st_r.weight;
          end
          st_nxt.weight = st_r.weight >> 1;
          st_nxt.trial  = decided | (st_r.weight >> 1);
          if (st_r.weight[0]) begin
            st_nxt.trial = decided;
            st_nxt.phase = scs_pkg::SCS_LATCH;
          end
        end else begin
          st_nxt.tick = st_r.tick + 8'h01;
        end
      end
      // Format is sampled here, so a mode write during the search
      // still applies to the result that is about to be held
      scs_pkg::SCS_LATCH: begin
        st_nxt.held  = scs_code(st_r.trial,
                                st_r.mode[scs_pkg::MODE_OB_SEL]);
        st_nxt.done  = 1'b1;
        st_nxt.phase = scs_pkg::SCS_TRACK;
      end
      default: begin
        st_nxt.phase = scs_pkg::SCS_TRACK;
      end
    endcase
  end

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r.start_sync <= 2'h0;
      st_r.start_prev <= 1'b0;
      st_r.phase      <= scs_pkg::SCS_TRACK;
      st_r.trial      <= RES_W'(0);
      st_r.weight     <= RES_W'(0);
      st_r.tick       <= 8'h00;
      st_r.mode       <= scs_pkg::MODE_RST_VAL;
      st_r.held       <= RES_W'(scs_pkg::RES_RST_VAL);
      st_r.done       <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign mode_rdata           = st_r.mode;
  assign result_data          = st_r.held;
  assign capacitive_trial_dac = st_r.trial;
  // Comparator and trial DAC only draw power during the search
  always_comb begin
    status                    = '0;
    status.conv_busy          = (st_r.phase != scs_pkg::SCS_TRACK);
    status.conv_done          = st_r.done;
    status.analog_active      = (st_r.phase == scs_pkg::SCS_CONVERT);
    status.sample_switch_open = (st_r.phase != scs_pkg::SCS_TRACK);
  end

  // A zero reference input forces both buffers off whatever the
  // mode bits say, so an external reference is never fought
  always_comb begin
    refctl = '0;
    refctl.first_ref_buffer_enable =
      !st_r.mode[scs_pkg::MODE_REF1_PD]
      && !reference_buffer_input_zero;
    refctl.second_ref_buffer_enable =
      !st_r.mode[scs_pkg::MODE_REF2_PD]
      && !reference_buffer_input_zero;
  end

endmodule
`default_nettype wire

// File: scs_sequencer_tb_top.sv
/* Bench for the sequencer.
   Assumes the comparator stand-in and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module scs_sequencer_tb_top;
  logic mclk = 1'b0, sys_rst = 1'b1, start = 1'b0, rz = 1'b0, mw = 1'b0;
  logic [15:0] wd = 16'h0000, md;
  logic [19:0] lv = 20'h00000, dac, res;
  logic above;
  scs_pkg::scs_status_t st;
  scs_pkg::scs_refctl_t rc;
  int n_errors = 0, n_tests = 0, cyc = 0;
  always #5 mclk = ~mclk;
  scs_sequencer u_dut (.mclk(mclk), .sys_rst(sys_rst),
    .conversion_start_pin(start), .comparator_above(above),
    .reference_buffer_input_zero(rz), .mode_write(mw), .mode_wdata(wd),
    .mode_rdata(md), .capacitive_trial_dac(dac), .result_data(res),
    .status(st), .refctl(rc));
  scs_analog_model u_cmp (.level(lv), .dac(dac), .above(above));
  task automatic end_sim();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic conv(input logic [19:0] l, input logic [19:0] exp);
    int i, d;
    d = 0;
    @(negedge mclk);
    lv = l;
    start = 1'b1;
    for (i = 0; i < 150; i++) begin
      @(negedge mclk);
      if (i == 20) start = 1'b0;
      if (i == 25) start = 1'b1;
      if (st.conv_done === 1'b1) d = d * 256 + i;
    end
    chk(20'(d), 20'd63);
    chk(res, exp);
    start = 1'b0;
  endtask
  task automatic set_mode(input logic [15:0] m, input logic z, input logic [1:0] e);
    @(negedge mclk);
    wd = m;
    mw = 1'b1;
    @(negedge mclk);
    mw = 1'b0;
    rz = z;
    #1;
    chk(20'(md), 20'(m));
    chk(20'(rc), 20'(e));
  endtask
  task automatic first_reset();
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    chk({md, 2'b00, rc}, 20'h00003);
  endtask
  task automatic mid_reset();
    start = 1'b1;
    repeat (20) @(negedge mclk);
    sys_rst = 1'b1;
    #1;
    chk({md, 3'b000, st.conv_busy}, 20'h00000);
    @(negedge mclk);
    sys_rst = 1'b0;
    start = 1'b0;
  endtask
  initial begin
    first_reset();
    conv(20'hfffff, 20'h7ffff);
    conv(20'h80000, 20'h00000);
    conv(20'h7ffff, 20'hfffff);
    conv(20'h00000, 20'h80000);
    set_mode(16'h0002, 1'b0, 2'b11);
    conv(20'hfffff, 20'hfffff);
    conv(20'h80001, 20'h80001);
    conv(20'h00000, 20'h00000);
    set_mode(16'h0010, 1'b0, 2'b01);
    set_mode(16'h0001, 1'b0, 2'b10);
    set_mode(16'h0000, 1'b1, 2'b00);
    set_mode(16'h0002, 1'b0, 2'b11);
    mid_reset();
    conv(20'h80000, 20'h00000);
    end_sim();
  end
endmodule
`default_nettype wire
